/* design/cbcfg_window0.sv */
// Configuration header slice of a PCI-to-card bridge: secondary status, bus numbers,
// secondary latency timer and memory window 0 decode.
// Assumes the primary target presents one config access per cycle and event pulses from the datapath.
`timescale 1ns/1ps

module cbcfg_window0
    import cbcfg_pkg::*;
(
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire cbcfg_cfg_s   cfg,
    input  wire cbcfg_event_s evt,
    input  wire logic         cmd_mem_en,
    input  wire logic         cmd_serr_en,
    input  wire logic         cmd_perr_resp,
    input  wire logic         brctl_cserr_en,
    input  wire logic         brctl_w0_prefetch,
    input  wire logic         card16_present,
    input  wire logic         mem_req,
    input  wire logic [31:0]  mem_addr,
    input  wire logic         cfg1_req,
    input  wire logic [7:0]   cfg1_bus,
    output logic       [31:0] cfg_rdata,
    output logic              serr_out,
    output logic              cfg_to_type0,
    output logic              cfg_to_type1,
    output logic              w0_hit,
    output logic              w0_prefetch,
    output logic       [15:0] sec_status,
    output logic       [7:0]  sec_latency
);

    cbcfg_state_s st_reg;
    cbcfg_state_s st_next;

    // Merge byte lanes of a write into an old dword
    function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic [15:0] evt_set;
    logic [15:0] clr_mask;
    logic [31:0] bus_dw;
    logic [31:0] lim_full;
    logic        wr_stat;
    logic        wr_bus;

    always_comb begin
        st_next = st_reg;
        evt_set = 16'h0000;
        evt_set[cbcfg_st_par_det]    = evt.par_err;
        evt_set[cbcfg_st_rx_serr]    = evt.rx_serr;
        evt_set[cbcfg_st_mabort]     = evt.mabort && evt.was_master;
        evt_set[cbcfg_st_rx_tabort]  = evt.rx_tabort && evt.was_master;
        evt_set[cbcfg_st_sig_tabort] = evt.sig_tabort;
        evt_set[cbcfg_st_dperr] = evt.dperr && evt.was_master && cmd_perr_resp;

        wr_stat  = cfg.wr && (cfg.addr[7:2] == cbcfg_dw_status[7:2]);
        clr_mask = 16'h0000;
        if (wr_stat) begin
            clr_mask = cfg.wdata[31:16] & {{8{cfg.be[3]}}, {8{cfg.be[2]}}};
        end
        // Set wins over clear so an event never slips through a clearing write
        st_next.sec_status = ((st_reg.sec_status & ~clr_mask) | evt_set)
                             & cbcfg_status_w1c;
        st_next.sec_status[10:9] = cbcfg_devsel_med;

        wr_bus = cfg.wr && (cfg.addr[7:2] == cbcfg_dw_busnum[7:2]);
        bus_dw = {st_reg.lat_timer, st_reg.sub_bus, st_reg.sec_bus, st_reg.prim_bus};
        if (wr_bus) begin
            bus_dw = merge_be(bus_dw, cfg.wdata, cfg.be);
        end
        st_next.prim_bus  = bus_dw[7:0];
        st_next.sec_bus   = bus_dw[15:8];
        st_next.sub_bus   = bus_dw[23:16];
        st_next.lat_timer = bus_dw[31:24] & cbcfg_lat_mask;

        if (cfg.wr && (cfg.addr[7:2] == cbcfg_dw_w0_base[7:2])) begin
            st_next.w0_base = merge_be(st_reg.w0_base, cfg.wdata, cfg.be)
                              & cbcfg_win_mask;
        end
        if (cfg.wr && (cfg.addr[7:2] == cbcfg_dw_w0_limit[7:2])) begin
            st_next.w0_limit = merge_be(st_reg.w0_limit, cfg.wdata, cfg.be)
                               & cbcfg_win_mask;
        end

        st_next.rdata = 32'h00000000;
        if (cfg.rd) begin
            unique case (cfg.addr[7:2])
                cbcfg_dw_status[7:2]:   st_next.rdata = {st_reg.sec_status, 16'h0000};
                cbcfg_dw_busnum[7:2]:   st_next.rdata = {st_reg.lat_timer, st_reg.sub_bus,
                                                         st_reg.sec_bus, st_reg.prim_bus};
                cbcfg_dw_w0_base[7:2]:  st_next.rdata = st_reg.w0_base;
                cbcfg_dw_w0_limit[7:2]: st_next.rdata = st_reg.w0_limit;
                default:                st_next.rdata = 32'h00000000;
            endcase
        end

        // Primary system error follows each received card error pulse while brctl_cserr_en and cmd_serr_en are both set
        st_next.serr = evt.rx_serr && brctl_cserr_en && cmd_serr_en;

        // Only primary-side Type 1 requests arrive here; card-side ones are never decoded
        st_next.cfg_type0 = cfg1_req && (cfg1_bus == st_reg.sec_bus);
        st_next.cfg_type1 = cfg1_req && (cfg1_bus > st_reg.sec_bus)
                            && (cfg1_bus < st_reg.sub_bus);

        lim_full = st_reg.w0_limit | cbcfg_win_low_ones;
        // Limit below base leaves the range empty, so no hit is possible
        st_next.w0_hit = mem_req && cmd_mem_en && !card16_present
                         && (mem_addr >= st_reg.w0_base)
                         && (mem_addr <= lim_full);
        st_next.w0_prefetch = brctl_w0_prefetch;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.sec_status <= cbcfg_status_reset;
        end else begin
            st_reg <= st_next;
        end
    end

    assign cfg_rdata    = st_reg.rdata;
    assign serr_out     = st_reg.serr;
    assign cfg_to_type0 = st_reg.cfg_type0;
    assign cfg_to_type1 = st_reg.cfg_type1;
    assign w0_hit       = st_reg.w0_hit;
    assign w0_prefetch  = st_reg.w0_prefetch;
    assign sec_status   = st_reg.sec_status;
    assign sec_latency  = st_reg.lat_timer;

endmodule

/* pkg/cbcfg_pkg.sv */
// Package for the bridge configuration window block: offsets, field positions, resets.
// Assumes a configuration-space port with byte address, byte enables and 32-bit dword data.
package cbcfg_pkg;

    // Configuration dword addresses (byte address bits 7:2 select the dword)
    localparam logic [7:0] cbcfg_dw_status   = 8'h14; // status in upper half, byte lanes 2,3
    localparam logic [7:0] cbcfg_dw_busnum   = 8'h18;
    localparam logic [7:0] cbcfg_dw_w0_base  = 8'h1c;
    localparam logic [7:0] cbcfg_dw_w0_limit = 8'h20;

    // Byte offsets as printed
    localparam logic [7:0] cbcfg_off_sec_status = 8'h16;
    localparam logic [7:0] cbcfg_off_prim_bus   = 8'h18;
    localparam logic [7:0] cbcfg_off_sec_bus    = 8'h19;
    localparam logic [7:0] cbcfg_off_sub_bus    = 8'h1a;
    localparam logic [7:0] cbcfg_off_lat_timer  = 8'h1b;

    // Secondary status field positions
    localparam int cbcfg_st_par_det   = 15;
    localparam int cbcfg_st_rx_serr   = 14;
    localparam int cbcfg_st_mabort    = 13;
    localparam int cbcfg_st_rx_tabort = 12;
    localparam int cbcfg_st_sig_tabort = 11;
    localparam int cbcfg_st_dperr     = 8;

    localparam logic [15:0] cbcfg_status_reset = 16'h0200;
    localparam logic [15:0] cbcfg_status_w1c   = 16'hf900;
    localparam logic [1:0]  cbcfg_devsel_med   = 2'h1;
    localparam logic [7:0]  cbcfg_lat_mask     = 8'hf8;
    localparam logic [31:0] cbcfg_win_mask     = 32'hfffff000;
    localparam logic [31:0] cbcfg_win_low_ones = 32'h00000fff;

    // Status events reported by the bridge datapath, one-cycle pulses
    typedef struct packed {
        logic par_err;
        logic rx_serr;
        logic mabort;
        logic rx_tabort;
        logic sig_tabort;
        logic dperr;
        logic was_master;
    } cbcfg_event_s;

    // Configuration access from the primary target
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } cbcfg_cfg_s;

    typedef struct packed {
        logic [15:0] sec_status;
        logic [7:0]  prim_bus;
        logic [7:0]  sec_bus;
        logic [7:0]  sub_bus;
        logic [7:0]  lat_timer;
        logic [31:0] w0_base;
        logic [31:0] w0_limit;
        logic [31:0] rdata;
        logic        serr;
        logic        cfg_type0;
        logic        cfg_type1;
        logic        w0_hit;
        logic        w0_prefetch;
    } cbcfg_state_s;

endpackage

/* verif/cbcfg_card_model.sv */
// Card-side event source: replays a requested event set as one-cycle pulses.
// Assumes the bench raises req for exactly one cycle.
`timescale 1ns/1ps
module cbcfg_card_model
    import cbcfg_pkg::*;
(
    input  wire logic         clock,
    input  wire cbcfg_event_s req,
    output cbcfg_event_s      evt
);
    // Launched on the edge so the bridge sees a clean full-cycle pulse
    always @(posedge clock) begin
        evt <= req;
    end
endmodule

/* verif/cbcfg_window0_assertions.sv */
// Checker for the window 0 configuration slice, bound to its ports.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module cbcfg_chk
    import cbcfg_pkg::*;
(
    input wire logic         clock,
    input wire logic         rst,
    input wire cbcfg_cfg_s   cfg,
    input wire cbcfg_event_s evt,
    input wire logic         cmd_mem_en,
    input wire logic         cmd_serr_en,
    input wire logic         cmd_perr_resp,
    input wire logic         brctl_cserr_en,
    input wire logic         card16_present,
    input wire logic         serr_out,
    input wire logic         w0_hit,
    input wire logic [15:0]  sec_status,
    input wire logic [7:0]   sec_latency
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_clr15;
        cfg.wr && cfg.addr[7:2] == 6'h05 && cfg.be[3] && cfg.wdata[31];
    endsequence
    a_w1c_clear: assert property (s_clr15 ##0 !evt.par_err |=> !sec_status[15])
        else $error("status bit 15 not cleared");
    a_fixed_bits: assert property ((sec_status & 16'h06ff) == 16'h0200)
        else $error("status fixed bits wrong");
    a_par_set: assert property (evt.par_err |=> sec_status[15])
        else $error("parity event lost");
    a_no_set14: assert property ($rose(sec_status[14]) |-> $past(evt.rx_serr))
        else $error("bit 14 set without cause");
    a_serr_fwd: assert property (evt.rx_serr && cmd_serr_en && brctl_cserr_en |=> serr_out)
        else $error("system error not forwarded");
    a_serr_cause: assert property (serr_out |-> $past(evt.rx_serr))
        else $error("system error without cause");
    a_mabort_set: assert property (evt.mabort && evt.was_master |=> sec_status[13])
        else $error("master abort lost");
    a_dperr_gate: assert property ($rose(sec_status[8]) |-> $past(cmd_perr_resp))
        else $error("bit 8 set with response off");
    a_hit_gate: assert property (w0_hit |-> $past(cmd_mem_en) && !$past(card16_present))
        else $error("window hit while disabled");
    a_lat_low: assert property (sec_latency[2:0] == 3'h0)
        else $error("latency low bits set");
endmodule
bind cbcfg_window0 cbcfg_chk cbcfg_chk_i (.*);

/* verif/cbcfg_window0_tb.sv */
// Self-checking bench for the window 0 configuration slice.
// Assumes the card model and the bound checker compile alongside.
`timescale 1ns/1ps
module cbcfg_window0_tb;
    import cbcfg_pkg::*;
    logic         clock = 0, rst = 1, mem_req = 0, cfg1_req = 0, card16_present = 0;
    logic         cmd_mem_en = 1, cmd_serr_en = 1, cmd_perr_resp = 1;
    logic         brctl_cserr_en = 1, brctl_w0_prefetch = 1;
    logic         serr_out, cfg_to_type0, cfg_to_type1, w0_hit, w0_prefetch;
    logic [31:0]  mem_addr = '0, cfg_rdata, d, b;
    logic [7:0]   cfg1_bus = '0, sec_latency;
    logic [15:0]  sec_status;
    logic [2:0]   pk = '0;
    cbcfg_cfg_s   cfg = '0;
    cbcfg_event_s req = '0, evt;
    logic [31:0]  q[$];
    int           fails = 0, checks_done = 0, cyc = 0;
    cbcfg_window0 cbcfg_window0_i (.*);
    cbcfg_card_model cbcfg_card_model_i (.*);
    initial forever #12.5 clock = ~clock;
    task automatic step;
        @(posedge clock) #1;
    endtask
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // A read notes its expected data; a write carries its data
    task automatic acc(logic w, logic [7:0] a, logic [3:0] be, logic [31:0] v);
        if (!w) q.push_back(v);
        cfg = '{w, !w, a, be, w ? v : 32'h0};
        step;
        cfg = '0;
        step;
    endtask
    task automatic mem(logic [31:0] a, logic h);
        q.push_back({31'h0, h});
        mem_req = 1;
        mem_addr = a;
        step;
        mem_req = 0;
        step;
    endtask
    task automatic t1(logic [7:0] bus, logic [1:0] e);
        q.push_back({30'h0, e});
        cfg1_req = 1;
        cfg1_bus = bus;
        step;
        cfg1_req = 0;
        step;
    endtask
    task automatic ev(logic [6:0] e);
        req = e;
        step;
        req = '0;
        step;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc > 2000) begin
            fails++;
            end_sim;
        end
        pk <= {cfg.rd, mem_req, cfg1_req};
    end
    // Outputs launched on the rising edge are settled by the falling edge
    always @(negedge clock) begin
        if (pk != 3'h0)
            chk(pk[2] ? cfg_rdata : pk[1] ? {31'h0, w0_hit} : {30'h0, cfg_to_type0, cfg_to_type1}, q.pop_front());
    end
    initial begin
        d = $urandom(92770);
        b = ($urandom & 32'h7fffe000) | 32'h00002000;
        repeat (4) @(posedge clock);
        #1 rst = 0;
        acc(0, 8'h16, 4'hc, 32'h02000000);
        acc(0, 8'h40, 4'hf, 32'h0);
        acc(1, 8'h18, 4'hf, d);
        acc(0, 8'h18, 4'hf, d & 32'hf8ffffff);
        acc(1, 8'h1c, 4'hf, 32'hffffffff);
        acc(0, 8'h1c, 4'hf, 32'hfffff000);
        acc(1, 8'h18, 4'h6, 32'h00090500);
        for (int i = 3; i < 11; i++) t1(i[7:0], {i == 5, i > 5 && i < 9});
        acc(1, 8'h1c, 4'hf, b);
        acc(1, 8'h20, 4'hf, b | 32'h123);
        acc(0, 8'h20, 4'hf, b);
        mem(b, 1);
        mem(b + 32'hfff, 1);
        mem(b + 32'h1000, 0);
        mem(b - 1, 0);
        cmd_mem_en = 0;
        mem(b, 0);
        cmd_mem_en = 1;
        card16_present = 1;
        mem(b, 0);
        card16_present = 0;
        acc(1, 8'h20, 4'hf, b - 32'h1000);
        mem(b, 0);
        ev(7'h7f);
        acc(0, 8'h16, 4'hc, 32'hfb000000);
        acc(1, 8'h16, 4'hc, 32'h0);
        acc(0, 8'h16, 4'hc, 32'hfb000000);
        req = 7'h40;
        step;
        req = '0;
        acc(1, 8'h16, 4'hc, 32'hffff0000);
        acc(0, 8'h16, 4'hc, 32'h82000000);
        cmd_perr_resp = 0;
        ev(7'h13);
        acc(0, 8'h16, 4'hc, 32'ha2000000);
        chk({24'h0, sec_latency}, {24'h0, d[31:24] & 8'hf8});
        chk({31'h0, w0_prefetch}, 32'h1);
        brctl_w0_prefetch = 0;
        step;
        step;
        chk({31'h0, w0_prefetch}, 32'h0);
        step;
        step;
        chk(q.size(), 32'h0);
        end_sim;
    end
endmodule
